// ---- rtl/omr_regs.sv ----
// offset monitor readback and 48 kHz detection limit register bank
//
// Behaviour
// - differential monitor, top bit then low byte
// - monitor codes signed, quarter millivolt per count
// - common-mode monitor, same split and coding
// - writable 5-bit lower 48 kHz count limit
// - writable 5-bit upper 48 kHz count limit
`include "omr_params.svh"

module omr_regs (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // register access from the serial control port
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrEn,
    input  wire logic [7:0] regWrData,
    input  wire logic       regRdEn,
    output logic      [7:0] regRdData,
    // left channel offset compensator monitor codes
    input  wire logic [8:0] diffMonitorCode,
    input  wire logic [8:0] cmMonitorCode,
    // 48 kHz detection count limits toward the rate detector
    output logic      [4:0] rate48MinCount,
    output logic      [4:0] rate48UpperLimit
);

    // ********************************
    // monitor capture stages
    // ********************************
    omr_mon_if diffMon ();
    omr_mon_if cmMon ();

    omr_mon_capture diffCapture (
        .mclk    (mclk),
        .reset_n (reset_n),
        .rawCode (diffMonitorCode),
        .mon     (diffMon)
    );

    omr_mon_capture cmCapture (
        .mclk    (mclk),
        .reset_n (reset_n),
        .rawCode (cmMonitorCode),
        .mon     (cmMon)
    );

    // ********************************
    // helpers
    // ********************************
    // high byte of a monitor: stored reserved bits above, sign-carrying top bit in bit 0
    function automatic logic [7:0] monHigh(input logic [6:0] rsvd, input logic [8:0] code);
        monHigh = {rsvd, code[8]};
    endfunction

    // low byte of a monitor: the lower eight bits of the code
    function automatic logic [7:0] monLow(input logic [8:0] code);
        monLow = code[7:0];
    endfunction

    omr_pkg::omr_state_t state_reg;
    omr_pkg::omr_state_t state_next;

    // ********************************
    // write and read decode
    // ********************************
    // codes pass untouched: two's complement, so 0x0FF reads as 63.75 mV, 0x1FF as
    // -0.25 mV and 0x100 as -64.0 mV; scaling is left to software
    always_comb begin
        state_next = state_reg;
        // writes: only the stored bits take data, monitor bits are not storage
        if (regWrEn) begin
            unique case (regAddr)
                `OMR_ADDR_DIFFERENTIAL_PATH_HIGH: state_next.diffHighRsvd = regWrData[7:1];
                `OMR_ADDR_MIN_COUNT: begin
                    state_next.minRsvd  = regWrData[7:`OMR_LIMIT_RSVD_LSB];
                    state_next.minCount = regWrData[`OMR_LIMIT_MSB:0];
                end
                `OMR_ADDR_RSVD_4F:   state_next.rsvd4f = regWrData;
                `OMR_ADDR_MAX_COUNT: begin
                    state_next.maxRsvd  = regWrData[7:`OMR_LIMIT_RSVD_LSB];
                    state_next.maxCount = regWrData[`OMR_LIMIT_MSB:0];
                end
                `OMR_ADDR_RSVD_51:   state_next.rsvd51 = regWrData;
                `OMR_ADDR_RSVD_52:   state_next.rsvd52 = regWrData;
                `OMR_ADDR_RSVD_53:   state_next.rsvd53 = regWrData;
                `OMR_ADDR_CM_HIGH:   state_next.cmHighRsvd = regWrData[7:1];
                `OMR_ADDR_RSVD_56:   state_next.rsvd56 = regWrData;
                // low monitor bytes and unmapped offsets drop the write
                default:             state_next.rdData = state_reg.rdData;
            endcase
        end
        // reads: answer one cycle after the request, holds until the next read
        if (regRdEn) begin
            unique case (regAddr)
                `OMR_ADDR_DIFFERENTIAL_PATH_HIGH:
                    state_next.rdData = monHigh(state_reg.diffHighRsvd, diffMon.value);
                `OMR_ADDR_DIFFERENTIAL_PATH_LOW:  state_next.rdData = monLow(diffMon.value);
                `OMR_ADDR_MIN_COUNT: state_next.rdData = {state_reg.minRsvd, state_reg.minCount};
                `OMR_ADDR_RSVD_4F:   state_next.rdData = state_reg.rsvd4f;
                `OMR_ADDR_MAX_COUNT: state_next.rdData = {state_reg.maxRsvd, state_reg.maxCount};
                `OMR_ADDR_RSVD_51:   state_next.rdData = state_reg.rsvd51;
                `OMR_ADDR_RSVD_52:   state_next.rdData = state_reg.rsvd52;
                `OMR_ADDR_RSVD_53:   state_next.rdData = state_reg.rsvd53;
                `OMR_ADDR_CM_HIGH:
                    state_next.rdData = monHigh(state_reg.cmHighRsvd, cmMon.value);
                `OMR_ADDR_CM_LOW:    state_next.rdData = monLow(cmMon.value);
                `OMR_ADDR_RSVD_56:   state_next.rdData = state_reg.rsvd56;
                default:             state_next.rdData = `OMR_UNMAPPED_READ;
            endcase
        end
    end

    // ********************************
    // state register
    // ********************************
    // every stored bit, reserved ones too, comes out of reset at zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.diffHighRsvd <= 7'h00;
            state_reg.minRsvd      <= 3'h0;
            state_reg.minCount     <= `OMR_RESET_LIMIT;
            state_reg.rsvd4f       <= `OMR_RESET_BYTE;
            state_reg.maxRsvd      <= 3'h0;
            state_reg.maxCount     <= `OMR_RESET_LIMIT;
            state_reg.rsvd51       <= `OMR_RESET_BYTE;
            state_reg.rsvd52       <= `OMR_RESET_BYTE;
            state_reg.rsvd53       <= `OMR_RESET_BYTE;
            state_reg.cmHighRsvd   <= 7'h00;
            state_reg.rsvd56       <= `OMR_RESET_BYTE;
            state_reg.rdData       <= `OMR_RESET_BYTE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ********************************
    // outputs, all straight from flip-flops
    // ********************************
    // the limits are only 5 bits wide, so the nominal counts 863 and 2479 cannot be
    // held; software loads whatever scaled value the rate detector expects
    assign rate48MinCount   = state_reg.minCount;
    assign rate48UpperLimit = state_reg.maxCount;
    assign regRdData        = state_reg.rdData;

endmodule

// ---- common/omr_params.svh ----
// offsets, field positions and reset values of the offset monitor register bank
`ifndef OMR_PARAMS_SVH
`define OMR_PARAMS_SVH

// ********************************
// register offsets
// ********************************
`define OMR_ADDR_DIFFERENTIAL_PATH_HIGH   8'h4C
`define OMR_ADDR_DIFFERENTIAL_PATH_LOW    8'h4D
`define OMR_ADDR_MIN_COUNT   8'h4E
`define OMR_ADDR_RSVD_4F     8'h4F
`define OMR_ADDR_MAX_COUNT   8'h50
`define OMR_ADDR_RSVD_51     8'h51
`define OMR_ADDR_RSVD_52     8'h52
`define OMR_ADDR_RSVD_53     8'h53
`define OMR_ADDR_CM_HIGH     8'h54
`define OMR_ADDR_CM_LOW      8'h55
`define OMR_ADDR_RSVD_56     8'h56

// ********************************
// field widths and positions
// ********************************
`define OMR_MON_W            9
`define OMR_LIMIT_W          5
`define OMR_LIMIT_MSB        4
`define OMR_LIMIT_RSVD_LSB   5
`define OMR_MON_TOP_BIT      0

// ********************************
// reset values and fixed answers
// ********************************
`define OMR_RESET_BYTE       8'h00
`define OMR_RESET_LIMIT      5'h00
`define OMR_RESET_MON        9'h000
`define OMR_UNMAPPED_READ    8'h00

`endif

// ---- common/omr_pkg.sv ----
// types shared by the offset monitor register bank
package omr_pkg;

    // ********************************
    // state of the register bank
    // ********************************
    typedef struct packed {
        logic [6:0] diffHighRsvd;   // bits 7:1 of the differential high register
        logic [2:0] minRsvd;        // bits 7:5 of the lower limit register
        logic [4:0] minCount;       // lower 48 kHz count limit
        logic [7:0] rsvd4f;
        logic [2:0] maxRsvd;        // bits 7:5 of the upper limit register
        logic [4:0] maxCount;       // upper 48 kHz count limit
        logic [7:0] rsvd51;
        logic [7:0] rsvd52;
        logic [7:0] rsvd53;
        logic [6:0] cmHighRsvd;     // bits 7:1 of the common-mode high register
        logic [7:0] rsvd56;
        logic [7:0] rdData;         // registered read answer
    } omr_state_t;

    // ********************************
    // state of one monitor capture stage
    // ********************************
    typedef struct packed {
        logic [8:0] value;
    } omr_mon_state_t;

endpackage

// ---- common/omr_mon_if.sv ----
// carries one registered 9-bit offset monitor code to the register bank
interface omr_mon_if;
    logic [8:0] value;   // signed code, 0.25 mV per count

    modport src (output value);
    modport dst (input value);
endinterface

// ---- rtl/omr_mon_capture.sv ----
// registers one offset compensator monitor code before it reaches the register bank
`include "omr_params.svh"

module omr_mon_capture (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // code from the offset compensator
    input  wire logic [8:0] rawCode,
    // registered code toward the register bank
    omr_mon_if.src          mon
);

    omr_pkg::omr_mon_state_t state_reg;
    omr_pkg::omr_mon_state_t state_next;

    // the code is sampled every cycle; a read sees it at most one cycle old
    always_comb begin
        state_next       = state_reg;
        state_next.value = rawCode;
    end

    // ********************************
    // state register
    // ********************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg.value <= `OMR_RESET_MON;
        end else begin
            state_reg <= state_next;
        end
    end

    assign mon.value = state_reg.value;

endmodule

// ---- test/omr_regs_assertions.sv ----
// concurrent checks on the ports of the offset monitor register bank
module omr_regs_assertions (
    // clock and reset
    input wire logic       mclk,
    input wire logic       reset_n,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic       regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic       regRdEn,
    input wire logic [7:0] regRdData,
    // monitor codes and limits
    input wire logic [8:0] diffMonitorCode,
    input wire logic [8:0] cmMonitorCode,
    input wire logic [4:0] rate48MinCount,
    input wire logic [4:0] rate48UpperLimit
);
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // port relations
    // ********************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [1:0] warm;
    // monitor reads only compare once the capture stage holds a real code
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) warm <= 2'h0;
        else if (warm != 2'h3) warm <= warm + 2'h1;
    end
    property p_minWr;
        regWrEn && regAddr == 8'h4E |=> rate48MinCount == $past(regWrData[4:0]);
    endproperty
    property p_maxWr;
        regWrEn && regAddr == 8'h50 |=> rate48UpperLimit == $past(regWrData[4:0]);
    endproperty
    property p_minHold;
        !(regWrEn && regAddr == 8'h4E) |=> $stable(rate48MinCount);
    endproperty
    property p_minRd;
        regRdEn && regAddr == 8'h4E |=> regRdData[4:0] == $past(rate48MinCount);
    endproperty
    property p_maxHold;
        !(regWrEn && regAddr == 8'h50) |=> $stable(rate48UpperLimit);
    endproperty
    property p_maxRd;
        regRdEn && regAddr == 8'h50 |=> regRdData[4:0] == $past(rate48UpperLimit);
    endproperty
    // the code seen two edges back is the one the capture stage held when the read was taken
    property p_diffHigh;
        warm != 2'h0 && regRdEn && regAddr == 8'h4C
            |=> regRdData[0] == $past(diffMonitorCode[8], 2);
    endproperty
    property p_diffLow;
        warm != 2'h0 && regRdEn && regAddr == 8'h4D
            |=> regRdData == $past(diffMonitorCode[7:0], 2);
    endproperty
    property p_cmHigh;
        warm != 2'h0 && regRdEn && regAddr == 8'h54
            |=> regRdData[0] == $past(cmMonitorCode[8], 2);
    endproperty
    property p_cmLow;
        warm != 2'h0 && regRdEn && regAddr == 8'h55 |=> regRdData == $past(cmMonitorCode[7:0], 2);
    endproperty
    property p_unmapped;
        regRdEn && (regAddr < 8'h4C || regAddr > 8'h56) |=> regRdData == 8'h00;
    endproperty
    a_minWr: assert property (p_minWr) else $error("lower limit not loaded");
    a_maxWr: assert property (p_maxWr) else $error("upper limit not loaded");
    a_minHold: assert property (p_minHold) else $error("lower limit moved");
    a_minRd: assert property (p_minRd) else $error("lower limit readback wrong");
    a_diffHigh: assert property (p_diffHigh) else $error("differential_path top bit wrong");
    a_diffLow: assert property (p_diffLow) else $error("differential_path low byte wrong");
    a_cmLow: assert property (p_cmLow) else $error("cm low byte wrong");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_maxHold: assert property (p_maxHold) else $error("upper limit moved");
    a_maxRd: assert property (p_maxRd) else $error("upper limit readback wrong");
    a_cmHigh: assert property (p_cmHigh) else $error("cm top bit wrong");
    // covers are sequences so that a vacuous pass of an implication never counts as a hit
    c_minWr: cover property (regWrEn && regAddr == 8'h4E ##1 rate48MinCount == 5'h1F);
    c_diffLow: cover property (regRdEn && regAddr == 8'h4D && diffMonitorCode == 9'h100);
    c_unmapped: cover property (regRdEn && regAddr == 8'h57 ##1 regRdData == 8'h00);
    c_cmHigh: cover property (regRdEn && regAddr == 8'h54 && cmMonitorCode[8]);
endmodule
bind omr_regs omr_regs_assertions u_chk (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .diffMonitorCode(diffMonitorCode), .cmMonitorCode(cmMonitorCode),
    .rate48MinCount(rate48MinCount), .rate48UpperLimit(rate48UpperLimit));

// ---- test/tb_omr_regs.sv ----
// self-checking bench for the offset monitor register bank
module tb_omr_regs;
    timeunit 1ns;
    timeprecision 1ps;
    // ********************************
    // signals, tasks and tests
    // ********************************
    logic       mclk, reset_n, regWrEn, regRdEn;
    logic [7:0] regAddr, regWrData, regRdData;
    logic [8:0] diffMonitorCode, cmMonitorCode;
    logic [4:0] rate48MinCount, rate48UpperLimit;
    logic [8:0] codes [4] = '{9'h0FF, 9'h1FF, 9'h100, 9'h001};
    logic [7:0] rsv [5]   = '{8'h4F, 8'h51, 8'h52, 8'h53, 8'h56};
    int         n_fail    = 0;
    int         tests_run = 0;
    omr_regs dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
        .diffMonitorCode(diffMonitorCode), .cmMonitorCode(cmMonitorCode),
        .rate48MinCount(rate48MinCount), .rate48UpperLimit(rate48UpperLimit));
    // 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle write strobe; #1 lets the edge's updates land
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
        #1;
    endtask
    // read answer appears after the edge that takes the strobe
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        #1 chk(regRdData, exp);
    endtask
    task automatic final_report;
        $display("compared %0d, mismatched %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // watchdog far beyond the roughly 120 cycles the tests need
    initial begin
        #50us;
        n_fail++;
        final_report();
    end
    initial begin
        {reset_n, regWrEn, regRdEn, regAddr, regWrData} = '0;
        diffMonitorCode = 9'h000;
        cmMonitorCode = 9'h000;
        repeat (12) @(posedge mclk);
        reset_n <= 1'b1;
        for (int a = 8'h4C; a <= 8'h56; a++) rdc(8'(a), 8'h00);
        chk({3'h0, rate48MinCount}, 8'h00);
        chk({3'h0, rate48UpperLimit}, 8'h00);
        $display("test reset done");
        wr(8'h4E, 8'hFF);
        wr(8'h50, 8'hB5);
        chk({3'h0, rate48MinCount}, 8'h1F);
        chk({3'h0, rate48UpperLimit}, 8'h15);
        rdc(8'h4E, 8'hFF);
        rdc(8'h50, 8'hB5);
        $display("test limits done");
        foreach (rsv[i]) begin
            wr(rsv[i], rsv[i] ^ 8'hA5);
            rdc(rsv[i], rsv[i] ^ 8'hA5);
        end
        $display("test reserved done");
        // extreme codes: largest, minus one, most negative, plus one
        foreach (codes[i]) begin
            @(posedge mclk);
            diffMonitorCode <= codes[i];
            cmMonitorCode <= ~codes[i];
            wr(8'h4D, 8'h5A);
            rdc(8'h4C, {7'h00, codes[i][8]});
            rdc(8'h4D, codes[i][7:0]);
            rdc(8'h54, {7'h00, ~codes[i][8]});
            rdc(8'h55, ~codes[i][7:0]);
        end
        wr(8'h4C, 8'hFF);
        wr(8'h55, 8'hAA);
        rdc(8'h4C, 8'hFE);
        rdc(8'h55, 8'hFE);
        $display("test monitors done");
        wr(8'h57, 8'h5A);
        rdc(8'h57, 8'h00);
        rdc(8'h4B, 8'h00);
        $display("test unmapped done");
        final_report();
    end
endmodule
